// ==== design/bmec_bridge_dev.sv ====
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
// Functional notes
// - Bit 3 selects aliased guaranteed access mode
// - Aliased: posting on, priority request drops after ack
// - Plain guaranteed access: posting on, request held
// - No sideband requests while south bridge non-guaranteed
// - Bit 5 disables livelock prevention
// - Eight retries force 64-clock non-guaranteed window
// - Bit 6 disables retry window, default zero
// - Firmware chooses bit 6 by traffic pattern
// - Sixteen-bit unpopulated log at CCh, resets zero
// - Log bit n marks device ID n+16 unpopulated
// - Firmware scans IDs 16-31, logs all-ones answers
// - Logged missing device: claim, forward, master abort
// - Empty log: missing device handled by watchdog
// - No locks to shadowed firmware when aliased
// - Error command bit 1 converts address to bus error
module bmec_bridge_dev
  import bmec_pkg::*;
(
  input  wire logic    sys_clk,
  input  wire logic    nrst,
  bmec_link_if.dev     link,
  input  wire logic    inb_retry,
  input  wire logic    inb_done,
  output logic         treat_gat,
  output logic         posting_en,
  output logic         outbound_prio,
  output logic         nongat_window,
  output logic         livelock_guard
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_WAIT = 3'b010,
    S_DONE = 3'b100
  } bmec_state_t;

  function automatic logic unpop_hit(input logic [15:0] log_v,
                                     input logic [4:0]  dev);
    logic [4:0] idx;
    idx = dev - UNPOP_BASE_ID;
    unpop_hit = (dev >= UNPOP_BASE_ID) && log_v[idx[3:0]];
  endfunction

  bmec_state_t state_q;
  bmec_state_t state_d;
  logic [7:0]  dm_q;
  logic [31:0] ee_q;
  logic [15:0] log_q;
  logic [31:0] rdata_q;
  logic        fwd_q;
  logic [7:0]  wait_q;
  logic [3:0]  retry_q;
  logic [7:0]  win_q;
  logic        guard_q;
  logic        priority_bus_request_n_q;
  logic        served_q;
  logic        address_error_n_prev_q;
  logic        bus_error_n_q;

  // Decode
  wire         take      = (state_q == S_IDLE) && link.req;
  wire         is_wr     = take && (link.op == OP_CFG_WR);
  wire         is_rd     = take && (link.op == OP_CFG_RD);
  wire         is_scan   = take && (link.op == OP_SCAN_RD);
  wire         hit_dm    = (link.addr == OFS_DECODE_MODE);
  wire         hit_ee    = (link.addr == OFS_EXT_ERR_CMD);
  wire         hit_log   = (link.addr == OFS_UNPOP_LOG);
  wire         claim     = unpop_hit(log_q, link.addr[4:0]);
  wire         alias_on  = dm_q[DM_ALIAS_BIT];
  wire         llock_on  = !dm_q[DM_LLOCK_DIS];
  wire         traffic_on = !dm_q[DM_TRAFFIC_BIT];
  wire         win_act   = (win_q != 8'h00);
  wire         retry_hit = inb_retry && (retry_q == RETRY_LIMIT - 4'h1);
  wire         sb_ok     = link.sb_req && link.south_gat;
  wire         address_error_n_edge = address_error_n_prev_q && !link.address_error_n;
  wire [31:0]  rd_word;

  assign rd_word = hit_dm  ? {24'h000000, dm_q} :
                   hit_ee  ? ee_q :
                   hit_log ? {16'h0000, log_q} : 32'h00000000;

  // Served flag: memory ack seen for this request while aliased
  wire         served_d = sb_ok && alias_on &&
                          (served_q || (priority_bus_request_n_q && !link.memory_ack_sideband_n));
  wire         priority_bus_request_n_d   = sb_ok && !served_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (is_scan) begin
          state_d = S_WAIT;
        end else if (take) begin
          state_d = S_DONE;
        end
      end
      S_WAIT: begin
        if (wait_q == 8'h01) begin
          state_d = S_DONE;
        end
      end
      S_DONE: begin
        state_d = S_IDLE;
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      dm_q  <= DECODE_MODE_RST;
      ee_q  <= EXT_ERR_RST;
      log_q <= UNPOP_LOG_RST;
    end else if (is_wr) begin
      if (hit_dm) begin
        dm_q <= link.wdata[7:0];
      end else if (hit_ee) begin
        ee_q <= link.wdata;
      end else if (hit_log) begin
        log_q <= link.wdata[15:0];
      end
    end
  end

  // Answer data and claim timing
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 32'h00000000;
      fwd_q   <= 1'b0;
      wait_q  <= 8'h00;
    end else if (is_scan) begin
      rdata_q <= 32'hFFFFFFFF;
      fwd_q   <= claim;
      wait_q  <= claim ? MABORT_CYCLES : WDOG_CYCLES;
    end else if (is_rd) begin
      rdata_q <= rd_word;
      fwd_q   <= 1'b0;
    end else if (state_q == S_WAIT) begin
      wait_q  <= wait_q - 8'h01;
    end
  end

  // Retry count, traffic window, livelock guard
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      retry_q <= 4'h0;
      win_q   <= 8'h00;
      guard_q <= 1'b0;
    end else begin
      if (inb_done || retry_hit) begin
        retry_q <= 4'h0;
      end else if (inb_retry) begin
        retry_q <= retry_q + 4'h1;
      end
      if (retry_hit && traffic_on && !win_act) begin
        win_q <= NONGAT_CYCLES;
      end else if (win_act) begin
        win_q <= win_q - 8'h01;
      end
      if (inb_done || !llock_on) begin
        guard_q <= 1'b0;
      end else if (inb_retry && (retry_q == LLOCK_RETRIES - 4'h1)) begin
        guard_q <= 1'b1;
      end
    end
  end

  // Priority bus request handling
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      priority_bus_request_n_q   <= 1'b0;
      served_q <= 1'b0;
    end else begin
      priority_bus_request_n_q   <= priority_bus_request_n_d;
      served_q <= served_d;
    end
  end

  // Address error to bus error conversion
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      address_error_n_prev_q <= 1'b1;
      bus_error_n_q      <= 1'b0;
    end else begin
      address_error_n_prev_q <= link.address_error_n;
      bus_error_n_q      <= address_error_n_edge && ee_q[EE_ADDRESS_ERROR_N_BUS_ERROR_N];
    end
  end

  assign link.ack    = (state_q == S_DONE);
  assign link.rdata  = rdata_q;
  assign link.fwd    = fwd_q;
  assign link.priority_bus_request_n = !priority_bus_request_n_q;
  assign link.bus_error_n_out  = 1'b0;
  assign link.bus_error_n_oe_n = !bus_error_n_q;

  // Mode outputs
  assign treat_gat      = link.south_gat && !alias_on && !win_act;
  assign posting_en     = 1'b1;
  assign outbound_prio  = !win_act && !guard_q;
  assign nongat_window  = win_act;
  assign livelock_guard = guard_q;

endmodule

// ==== design/bmec_pkg.sv ====
package bmec_pkg;

  // Configuration offsets of the bridge
  localparam logic [7:0]  OFS_DECODE_MODE = 8'h48;
  localparam logic [7:0]  OFS_EXT_ERR_CMD = 8'hC0;
  localparam logic [7:0]  OFS_UNPOP_LOG   = 8'hCC;

  // Reset values
  localparam logic [7:0]  DECODE_MODE_RST = 8'h06;
  localparam logic [31:0] EXT_ERR_RST     = 32'h00000010;
  localparam logic [15:0] UNPOP_LOG_RST   = 16'h0000;

  // Field positions
  localparam int DM_ALIAS_BIT    = 3;
  localparam int DM_LLOCK_DIS    = 5;
  localparam int DM_TRAFFIC_BIT  = 6;
  localparam int EE_ADDRESS_ERROR_N_BUS_ERROR_N    = 1;
  localparam logic [4:0] UNPOP_BASE_ID = 5'h10;

  // Retry and window counts
  localparam logic [3:0] RETRY_LIMIT     = 4'h8;
  localparam logic [3:0] LLOCK_RETRIES   = 4'h4;
  localparam logic [7:0] NONGAT_CYCLES   = 8'h40;

  // Times and derived cycle counts
  localparam int CLK_PERIOD_NS   = 40;
  localparam int WDOG_TIME_NS    = 4000;
  localparam int MABORT_TIME_NS  = 240;
  localparam logic [7:0] WDOG_CYCLES   = 8'(WDOG_TIME_NS / CLK_PERIOD_NS);
  localparam logic [7:0] MABORT_CYCLES =
    8'((MABORT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Link operations
  typedef enum logic [1:0] {
    OP_CFG_RD  = 2'h0,
    OP_CFG_WR  = 2'h1,
    OP_SCAN_RD = 2'h2
  } bmec_op_t;

  // Controller register offsets
  localparam logic [7:0] HR_CMD    = 8'h00;
  localparam logic [7:0] HR_WDATA  = 8'h04;
  localparam logic [7:0] HR_RDATA  = 8'h08;
  localparam logic [7:0] HR_PINS   = 8'h0C;
  localparam logic [7:0] HR_STATUS = 8'h10;
  localparam logic [7:0] HR_MASK   = 8'h14;
  localparam logic [7:0] HR_LINK   = 8'h18;

  // Controller status bits
  localparam int ST_DONE    = 0;
  localparam int ST_BUS_ERROR_N    = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_BITS    = 3;

endpackage

// ==== design/bmec_link_if.sv ====
`timescale 1ns/1ps
interface bmec_link_if;
  logic        req;
  logic [1:0]  op;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        ack;
  logic [31:0] rdata;
  logic        fwd;
  logic        south_gat;
  logic        sb_req;
  logic        memory_ack_sideband_n;
  logic        priority_bus_request_n;
  logic        address_error_n;
  logic        bus_error_n_out;
  logic        bus_error_n_oe_n;
  logic        bus_error_n;
  logic        lock_n;

  // Open-drain wire with pull-up
  assign bus_error_n = bus_error_n_oe_n ? 1'b1 : bus_error_n_out;

  modport dev (
    input  req, op, addr, wdata, south_gat, sb_req, memory_ack_sideband_n,
           address_error_n, lock_n,
    output ack, rdata, fwd, priority_bus_request_n, bus_error_n_out, bus_error_n_oe_n
  );
  modport host (
    output req, op, addr, wdata, south_gat, sb_req, memory_ack_sideband_n,
           address_error_n, lock_n,
    input  ack, rdata, fwd, priority_bus_request_n, bus_error_n
  );
endinterface

// ==== design/bmec_host_ctl.sv ====
`timescale 1ns/1ps
module bmec_host_ctl
  import bmec_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  bmec_link_if.host        link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq
);

  logic        ack_q;
  logic [31:0] dat_q;
  logic        req_q;
  logic [1:0]  op_q;
  logic [7:0]  addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic        fwd_q;
  logic [3:0]  pins_q;
  logic        memory_ack_sideband_n_q;
  logic        alias_q;
  logic        bus_error_n_prev_q;
  logic [ST_BITS-1:0] stat_q;
  logic [ST_BITS-1:0] mask_q;

  // Decode
  wire        acc      = wb_cyc_i && wb_stb_i && !ack_q;
  wire        wr       = acc && wb_we_i && wb_sel_i[0];
  wire        go       = wr && (wb_adr_i == HR_CMD) && wb_dat_i[31] && !req_q;
  wire        done     = req_q && link.ack;
  wire        bus_error_n_ev  = bus_error_n_prev_q && !link.bus_error_n;
  wire        refused  = pins_q[1] && !pins_q[0];
  wire [ST_BITS-1:0] ev = {refused, bus_error_n_ev, done};
  wire        wr_stat  = wr && (wb_adr_i == HR_STATUS);
  wire [31:0] rd_word;

  assign rd_word =
    (wb_adr_i == HR_CMD)    ? {req_q, 15'h0000, addr_q, 6'h00, op_q} :
    (wb_adr_i == HR_WDATA)  ? wdata_q :
    (wb_adr_i == HR_RDATA)  ? rdata_q :
    (wb_adr_i == HR_PINS)   ? {28'h0000000, pins_q} :
    (wb_adr_i == HR_STATUS) ? {29'h00000000, stat_q} :
    (wb_adr_i == HR_MASK)   ? {29'h00000000, mask_q} :
    (wb_adr_i == HR_LINK)   ? {29'h00000000, fwd_q, alias_q,
                               !link.priority_bus_request_n} : 32'h00000000;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end else begin
      ack_q <= acc;
      dat_q <= rd_word;
    end
  end

  // Command and configuration access
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      req_q   <= 1'b0;
      op_q    <= 2'h0;
      addr_q  <= 8'h00;
      wdata_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      fwd_q   <= 1'b0;
      pins_q  <= 4'h0;
      mask_q  <= '0;
      alias_q <= 1'b0;
    end else begin
      if (go) begin
        req_q  <= 1'b1;
        op_q   <= wb_dat_i[1:0];
        addr_q <= wb_dat_i[15:8];
      end else if (done) begin
        req_q   <= 1'b0;
        rdata_q <= link.rdata;
        fwd_q   <= link.fwd;
      end
      if (go && (wb_dat_i[1:0] == OP_CFG_WR) && (wb_dat_i[15:8] == OFS_DECODE_MODE)) begin
        alias_q <= wdata_q[DM_ALIAS_BIT];
      end
      if (wr && (wb_adr_i == HR_WDATA)) begin
        wdata_q <= wb_dat_i;
      end
      if (wr && (wb_adr_i == HR_PINS)) begin
        pins_q <= wb_dat_i[3:0];
      end
      if (wr && (wb_adr_i == HR_MASK)) begin
        mask_q <= wb_dat_i[ST_BITS-1:0];
      end
    end
  end

  // Sideband acknowledge, status and event capture
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      memory_ack_sideband_n_q    <= 1'b0;
      bus_error_n_prev_q <= 1'b1;
      stat_q      <= '0;
    end else begin
      memory_ack_sideband_n_q    <= link.sb_req && !link.priority_bus_request_n;
      bus_error_n_prev_q <= link.bus_error_n;
      stat_q      <= (stat_q & ~(wr_stat ? wb_dat_i[ST_BITS-1:0] : '0)) | ev;
    end
  end

  assign link.req       = req_q;
  assign link.op        = op_q;
  assign link.addr      = addr_q;
  assign link.wdata     = wdata_q;
  assign link.south_gat = pins_q[0];
  assign link.sb_req    = pins_q[1] && pins_q[0];
  assign link.memory_ack_sideband_n = !memory_ack_sideband_n_q;
  assign link.address_error_n       = !pins_q[2];
  assign link.lock_n    = !(pins_q[3] && !alias_q);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign irq      = |(stat_q & mask_q);

endmodule

// ==== verif/bmec_link_properties.sv ====
`timescale 1ns/1ps
module bmec_link_properties
  import bmec_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        req,
  input wire logic [1:0]  op,
  input wire logic [7:0]  addr,
  input wire logic        ack,
  input wire logic [31:0] rdata,
  input wire logic        fwd,
  input wire logic        south_gat,
  input wire logic        sb_req,
  input wire logic        memory_ack_sideband_n,
  input wire logic        priority_bus_request_n,
  input wire logic        address_error_n,
  input wire logic        bus_error_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence s_scan;
    $rose(req) && op == OP_SCAN_RD;
  endsequence
  property p_cfg_ack;
    $rose(req) && op != OP_SCAN_RD |=> ack;
  endproperty
  property p_scan_fast;
    s_scan ##1 fwd |-> ##6 ack;
  endproperty
  property p_scan_slow;
    s_scan ##1 !fwd |-> ##100 ack;
  endproperty
  property p_low_id;
    s_scan and addr[4] == 1'b0 |=> !fwd;
  endproperty
  property p_scan_data;
    ack && op == OP_SCAN_RD |-> rdata == 32'hFFFFFFFF;
  endproperty
  property p_bus_error_n_src;
    $fell(bus_error_n) |-> $past(address_error_n, 2) && !$past(address_error_n);
  endproperty
  property p_bus_error_n_pulse;
    $fell(bus_error_n) |=> bus_error_n;
  endproperty
  property p_priority_bus_request_n_req;
    $rose(sb_req) |=> !priority_bus_request_n;
  endproperty
  property p_priority_bus_request_n_rel;
    $rose(priority_bus_request_n) && $past(sb_req) |-> !$past(memory_ack_sideband_n);
  endproperty
  property p_sb_gate;
    sb_req |-> south_gat;
  endproperty
  a_cfg_ack: assert property (p_cfg_ack) else $error("cfg ack late");
  a_scan_fast: assert property (p_scan_fast) else $error("abort timing");
  a_scan_slow: assert property (p_scan_slow) else $error("watchdog timing");
  a_low_id: assert property (p_low_id) else $error("low id forwarded");
  a_scan_data: assert property (p_scan_data) else $error("scan data");
  a_bus_error_n_src: assert property (p_bus_error_n_src) else $error("bus error cause");
  a_bus_error_n_pulse: assert property (p_bus_error_n_pulse) else $error("bus error width");
  a_priority_bus_request_n_req: assert property (p_priority_bus_request_n_req) else $error("priority_bus_request_n late");
  a_priority_bus_request_n_rel: assert property (p_priority_bus_request_n_rel) else $error("priority_bus_request_n release");
  a_sb_gate: assert property (p_sb_gate) else $error("sideband ungated");
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/1ps
module testbench
  import bmec_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        inb_retry = 1'b0;
  logic        inb_done = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h00000000;
  logic [31:0] wb_q;
  logic        wb_ack;
  logic        irq;
  logic        treat_gat;
  logic        posting_en;
  logic        outbound_prio;
  logic        nongat_window;
  logic        livelock_guard;
  logic [31:0] q;
  logic [31:0] v;
  logic [7:0]  ofs [4] = '{8'h48, 8'hC0, 8'hCC, 8'h44};
  logic [31:0] rst [4] = '{32'h00000006, 32'h00000010, 32'h00000000, 32'h00000000};
  logic [4:0]  ids [3] = '{5'h11, 5'h12, 5'h05};
  int          miscompares = 0;
  int          cmp_count = 0;
  int          r;
  always #20 sys_clk = ~sys_clk;
  bmec_link_if u_link();
  bmec_bridge_dev u_bmec_bridge_dev (.sys_clk(sys_clk), .nrst(nrst), .link(u_link.dev),
    .inb_retry(inb_retry), .inb_done(inb_done), .treat_gat(treat_gat),
    .posting_en(posting_en), .outbound_prio(outbound_prio), .nongat_window(nongat_window),
    .livelock_guard(livelock_guard));
  bmec_host_ctl u_bmec_host_ctl (.sys_clk(sys_clk), .nrst(nrst), .link(u_link.host),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_dat_i(wb_dat), .wb_sel_i(4'hF), .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .irq(irq));
  bmec_link_properties u_props (.sys_clk(sys_clk), .nrst(nrst), .req(u_link.req),
    .op(u_link.op), .addr(u_link.addr), .ack(u_link.ack), .rdata(u_link.rdata),
    .fwd(u_link.fwd), .south_gat(u_link.south_gat), .sb_req(u_link.sb_req),
    .memory_ack_sideband_n(u_link.memory_ack_sideband_n),
    .priority_bus_request_n(u_link.priority_bus_request_n),
    .address_error_n(u_link.address_error_n), .bus_error_n(u_link.bus_error_n));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string m);
    chk32({31'h0, got}, {31'h0, exp}, m);
  endtask
  task automatic hang;
    miscompares++;
    $display("wrong value at %0t: no answer", $time);
    give_verdict();
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    if (n >= 20) hang();
    q = wb_q;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic lop(input logic [1:0] op, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb(1'b1, HR_WDATA, d);
    wb(1'b1, HR_CMD, {1'b1, 15'h0000, a, 6'h00, op});
    do begin
      wb(1'b0, HR_STATUS, 32'h0);
      n++;
    end while (q[ST_DONE] !== 1'b1 && n < 200);
    if (n >= 200) hang();
    wb(1'b1, HR_STATUS, 32'h00000001);
    wb(1'b0, HR_RDATA, 32'h0);
  endtask
  task automatic pulse(input int n, input logic done);
    repeat (n) begin
      @(posedge sys_clk);
      inb_retry <= !done;
      inb_done  <= done;
      @(posedge sys_clk);
      inb_retry <= 1'b0;
      inb_done  <= 1'b0;
    end
  endtask
  task automatic win(input int exp);
    int n;
    n = 0;
    repeat (80) begin
      @(posedge sys_clk);
      if (nongat_window === 1'b1) n++;
    end
    chk32(32'(n), 32'(exp), "window length");
    pulse(1, 1'b1);
  endtask
  initial begin
    void'($urandom(15945));
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    foreach (ofs[i]) begin
      lop(OP_CFG_RD, ofs[i], 32'h0);
      chk32(q, rst[i], "cfg reset");
    end
    wb(1'b0, 8'h1C, 32'h0);
    chk32(q, 32'h0, "unmapped");
    $display("test 1 done");
    v = $urandom;
    lop(OP_CFG_WR, OFS_UNPOP_LOG, v);
    lop(OP_CFG_RD, OFS_UNPOP_LOG, 32'h0);
    chk32(q, {16'h0000, v[15:0]}, "log width");
    lop(OP_CFG_WR, OFS_UNPOP_LOG, 32'h00000002);
    foreach (ids[i]) begin
      lop(OP_SCAN_RD, {3'h0, ids[i]}, 32'h0);
      chk32(q, 32'hFFFFFFFF, "scan data");
      wb(1'b0, HR_LINK, 32'h0);
      chk1(q[2], ids[i] == 5'h11, "forwarded");
    end
    $display("test 2 done");
    r = $urandom_range(7, 1);
    pulse(r, 1'b0);
    pulse(1, 1'b1);
    win(0);
    pulse(4, 1'b0);
    @(posedge sys_clk);
    chk1(livelock_guard, 1'b1, "guard");
    chk1(outbound_prio, 1'b0, "prio low");
    pulse(4, 1'b0);
    win(64);
    @(posedge sys_clk);
    chk1(livelock_guard, 1'b0, "guard clear");
    chk1(outbound_prio, 1'b1, "prio back");
    lop(OP_CFG_WR, OFS_DECODE_MODE, 32'h00000066);
    pulse(8, 1'b0);
    @(posedge sys_clk);
    chk1(livelock_guard, 1'b0, "guard off");
    win(0);
    $display("test 3 done");
    for (int e = 0; e < 2; e++) begin
      lop(OP_CFG_WR, OFS_EXT_ERR_CMD, 32'h00000010 | 32'(e * 2));
      wb(1'b1, HR_MASK, 32'h00000002);
      wb(1'b1, HR_PINS, 32'h00000004);
      wb(1'b1, HR_PINS, 32'h00000000);
      wb(1'b0, HR_STATUS, 32'h0);
      chk1(q[ST_BUS_ERROR_N], e == 1, "bus error");
      chk1(irq, e == 1, "irq");
      wb(1'b1, HR_STATUS, 32'h00000002);
      chk1(irq, 1'b0, "irq clear");
    end
    $display("test 4 done");
    for (int al = 0; al < 2; al++) begin
      lop(OP_CFG_WR, OFS_DECODE_MODE, 32'h00000066 | 32'(al * 8));
      wb(1'b1, HR_PINS, 32'h0000000B);
      repeat (8) @(posedge sys_clk);
      chk1(treat_gat, al == 0, "treat gat");
      chk1(posting_en, 1'b1, "posting");
      chk1(u_link.priority_bus_request_n, al == 1, "priority_bus_request_n");
      chk1(u_link.lock_n, al == 1, "lock");
      wb(1'b1, HR_PINS, 32'h00000000);
    end
    wb(1'b1, HR_PINS, 32'h00000002);
    repeat (4) @(posedge sys_clk);
    chk1(u_link.sb_req, 1'b0, "sideband gated");
    chk1(u_link.priority_bus_request_n, 1'b1, "no priority_bus_request_n");
    wb(1'b0, HR_STATUS, 32'h0);
    chk1(q[ST_REFUSED], 1'b1, "refused");
    wb(1'b1, HR_PINS, 32'h00000000);
    wb(1'b1, HR_STATUS, 32'h00000004);
    $display("test 5 done");
    give_verdict();
  end
endmodule
